// ==== pkg/rcc_pkg.sv ====
// package: register map, field layout, crc constants and carriers of the rx check block
package rcc_pkg;
    localparam int          ADDR_W          = 16;
    localparam logic [15:0] RCC_IDX_WAIT    = 16'h0011;
    localparam logic [15:0] RCC_IDX_CRC     = 16'h0012;
    localparam logic [15:0] RCC_IDX_STAT    = 16'h0030;

    localparam int          WAIT_VAL_LSB    = 8;
    localparam int          WAIT_VAL_W      = 20;
    localparam int          WAIT_PRE_LSB    = 0;
    localparam int          WAIT_PRE_W      = 8;

    localparam int          CRC_PRESET_LSB  = 16;
    localparam int          CRC_PAR_TYPE    = 11;
    localparam int          CRC_PAR_EN      = 10;
    localparam int          CRC_KEEP_COLL   = 9;
    localparam int          CRC_ALIGN_LSB   = 6;
    localparam int          CRC_SEL_LSB     = 3;
    localparam int          CRC_TYPE5       = 2;
    localparam int          CRC_INV         = 1;
    localparam int          CRC_EN          = 0;

    localparam int          STAT_ERR        = 0;
    localparam int          STAT_CRC_OK     = 1;
    localparam int          STAT_GUARD      = 2;
    localparam int          STAT_CNT_LSB    = 8;

    localparam logic [2:0]  SEL_ZERO        = 3'h0;
    localparam logic [2:0]  SEL_6363        = 3'h1;
    localparam logic [2:0]  SEL_A671        = 3'h2;
    localparam logic [2:0]  SEL_FFFF        = 3'h3;
    localparam logic [2:0]  SEL_0012        = 3'h4;
    localparam logic [2:0]  SEL_E012        = 3'h5;
    localparam logic [2:0]  SEL_ARB         = 3'h7;

    localparam logic [15:0] PRESET_ZERO     = 16'h0000;
    localparam logic [15:0] PRESET_6363     = 16'h6363;
    localparam logic [15:0] PRESET_A671     = 16'hA671;
    localparam logic [15:0] PRESET_FFFF     = 16'hFFFF;
    localparam logic [15:0] PRESET_0012     = 16'h0012;
    localparam logic [15:0] PRESET_E012     = 16'hE012;

    localparam logic [15:0] CRC16_POLY      = 16'h8408;
    localparam logic [15:0] CRC5_POLY       = 16'h0012;
    localparam logic [15:0] CRC5_MASK       = 16'h001F;
    localparam logic [15:0] CRC16_RESIDUE   = 16'h0000;
    localparam logic [15:0] CRC16_RES_INV   = 16'hF0B8;
    localparam logic [15:0] CRC5_RESIDUE    = 16'h0000;

    localparam logic [2:0]  ALIGN_LAST      = 3'h7;

    typedef enum logic [1:0] {MODE_A, MODE_B, MODE_JIS, MODE_OTHER} rcc_mode_type;

    typedef struct packed {
        logic [15:0] preset;
        logic        par_type;
        logic        par_en;
        logic        keep_coll;
        logic [2:0]  align;
        logic [2:0]  sel;
        logic        crc5;
        logic        checksum_invert;
        logic        crc_en;
    } rcc_cfg_type;

    localparam rcc_cfg_type CFG_RESET = '0;

    typedef struct packed {
        logic valid;
        logic data;
        logic coll;
    } rcc_bit_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rcc_byte_type;

    // reserved code 110b falls back to a zero preset
    function automatic logic [15:0] rcc_preset(input logic [2:0] sel, input logic [15:0] arb,
                                               input logic crc5);
        logic [15:0] p;
        p = PRESET_ZERO;
        case (sel)
            SEL_6363: p = PRESET_6363;
            SEL_A671: p = PRESET_A671;
            SEL_FFFF: p = PRESET_FFFF;
            SEL_0012: p = PRESET_0012;
            SEL_E012: p = PRESET_E012;
            SEL_ARB:  p = arb;
            default:  p = PRESET_ZERO;
        endcase
        return crc5 ? {8'h00, p[7:0]} : p;
    endfunction : rcc_preset
endpackage : rcc_pkg

// ==== core/rcc_crc.sv ====
// bit-serial receive crc engine, 16-bit or 5-bit, lsb first
`timescale 1ns/1ps
`default_nettype none
module rcc_crc (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        init,
    input  wire logic [15:0] preset,
    input  wire logic        crc5,
    input  wire logic        bit_en,
    input  wire logic        bit_in,
    output logic [15:0]      crc_r
);
    import rcc_pkg::*;

    logic        fb;
    logic [15:0] poly;
    logic [15:0] mask;
    logic [15:0] crc_nxt;

    assign fb      = crc_r[0] ^ bit_in;
    assign poly    = crc5 ? CRC5_POLY : CRC16_POLY;
    assign mask    = crc5 ? CRC5_MASK : 16'hFFFF;
    assign crc_nxt = ({1'b0, crc_r[15:1]} ^ (fb ? poly : 16'h0000)) & mask;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            crc_r <= 16'h0000;
        end else if (init) begin
            crc_r <= preset & mask;
        end else if (bit_en) begin
            crc_r <= crc_nxt;
        end
    end
endmodule : rcc_crc
`default_nettype wire

// ==== core/rcc_guard.sv ====
// receive guard timer: prescaled down-counter started at end of transmission
`timescale 1ns/1ps
`default_nettype none
module rcc_guard #(
    parameter int CNT_W = 20,
    parameter int PRE_W = 8
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] reload,
    input  wire logic [PRE_W-1:0] presc,
    output logic                  busy,
    output logic [CNT_W-1:0]      count_r
);
    logic [PRE_W-1:0] pre_r;
    logic             tick;

    assign tick = (pre_r == '0);
    assign busy = (count_r != '0);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_r <= '0;
            pre_r   <= '0;
        end else if (start) begin
            count_r <= reload;
            pre_r   <= presc;
        end else if (busy) begin
            pre_r   <= tick ? presc : pre_r - 1'b1;
            count_r <= tick ? count_r - 1'b1 : count_r;
        end
    end
endmodule : rcc_guard
`default_nettype wire

// ==== core/rcc_rx_check.sv ====
// receive check block: config registers, guard, byte assembly, parity and crc check
`timescale 1ns/1ps
`default_nettype none
module rcc_rx_check #(
    parameter int GUARD_W = 20,
    parameter int PRESC_W = 8
) (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [rcc_pkg::ADDR_W-1:0]  addr,
    input  wire logic [31:0]                 wdata,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic [31:0]                      rdata_r,
    input  wire logic                        tx_end,
    input  wire logic                        rx_start,
    input  wire logic                        rx_end,
    input  wire rcc_pkg::rcc_bit_type        rx_bit,
    input  wire logic                        auto_detect_en,
    input  wire logic                        mode_valid,
    input  wire rcc_pkg::rcc_mode_type       mode,
    input  wire logic                        parity_stop_en,
    output rcc_pkg::rcc_byte_type            byte_out_r,
    output logic                             integrity_err_r,
    output logic                             crc_ok_r,
    output logic                             frame_done_r,
    output logic                             rx_open_r
);
    import rcc_pkg::*;

    generate
        if (GUARD_W < 1 || GUARD_W > WAIT_VAL_W || PRESC_W < 1 || PRESC_W > WAIT_PRE_W) begin : g_chk
            $error("rcc_rx_check: guard widths out of range");
        end
    endgenerate

    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PARITY} rcc_rx_state_type;

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    rcc_cfg_type        cfg_r;
    rcc_cfg_type        cfg_nxt;
    logic [GUARD_W-1:0] wait_val_r;
    logic [PRESC_W-1:0] wait_pre_r;
    logic               wr_wait;
    logic               wr_crc;
    logic               det_hit;
    logic [31:0]        rd_wait;
    logic [31:0]        rd_crc;
    logic [31:0]        rd_stat;
    logic [31:0]        rd_mux;
    logic               guard_busy;
    logic [GUARD_W-1:0] guard_cnt;

    assign wr_wait = wr_en && (addr == RCC_IDX_WAIT);
    assign wr_crc  = wr_en && (addr == RCC_IDX_CRC);
    assign det_hit = auto_detect_en && mode_valid;

    // detector update lands after a same-cycle software write, so it wins
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_crc) begin
            cfg_nxt.preset    = wdata[CRC_PRESET_LSB +: 16];
            cfg_nxt.par_type  = wdata[CRC_PAR_TYPE];
            cfg_nxt.par_en    = wdata[CRC_PAR_EN];
            cfg_nxt.keep_coll = wdata[CRC_KEEP_COLL];
            cfg_nxt.align     = wdata[CRC_ALIGN_LSB +: 3];
            cfg_nxt.sel       = wdata[CRC_SEL_LSB +: 3];
            cfg_nxt.crc5      = wdata[CRC_TYPE5];
            cfg_nxt.checksum_invert = wdata[CRC_INV];
            cfg_nxt.crc_en    = wdata[CRC_EN];
        end
        if (det_hit) begin
            unique case (mode)
                MODE_A: begin
                    cfg_nxt.par_en   = 1'b1;
                    cfg_nxt.par_type = 1'b1;
                    cfg_nxt.sel      = SEL_6363;
                    cfg_nxt.checksum_invert = 1'b0;
                end
                MODE_B: begin
                    cfg_nxt.sel    = SEL_FFFF;
                    cfg_nxt.checksum_invert = 1'b1;
                    cfg_nxt.crc_en = 1'b1;
                end
                MODE_JIS: begin
                    cfg_nxt.sel    = SEL_ZERO;
                    cfg_nxt.checksum_invert = 1'b0;
                    cfg_nxt.crc_en = 1'b1;
                end
                MODE_OTHER: begin
                    cfg_nxt = cfg_nxt;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_r      <= CFG_RESET;
            wait_val_r <= '0;
            wait_pre_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
            if (wr_wait) begin
                wait_val_r <= wdata[WAIT_VAL_LSB +: GUARD_W];
                wait_pre_r <= wdata[WAIT_PRE_LSB +: PRESC_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path: unused upper bits and unmapped addresses read zero

    always_comb begin
        rd_wait = 32'h0000_0000;
        rd_wait[WAIT_VAL_LSB +: GUARD_W] = wait_val_r;
        rd_wait[WAIT_PRE_LSB +: PRESC_W] = wait_pre_r;
        rd_stat = 32'h0000_0000;
        rd_stat[STAT_ERR]    = integrity_err_r;
        rd_stat[STAT_CRC_OK] = crc_ok_r;
        rd_stat[STAT_GUARD]  = guard_busy;
        rd_stat[STAT_CNT_LSB +: GUARD_W] = guard_cnt;
    end

    assign rd_crc = {cfg_r.preset, 4'h0, cfg_r.par_type, cfg_r.par_en, cfg_r.keep_coll,
                     cfg_r.align, cfg_r.sel, cfg_r.crc5, cfg_r.checksum_invert, cfg_r.crc_en};
    assign rd_mux = (addr == RCC_IDX_WAIT) ? rd_wait :
                    (addr == RCC_IDX_CRC)  ? rd_crc  :
                    (addr == RCC_IDX_STAT) ? rd_stat : 32'h0000_0000;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rd_en ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // guard timer; the host must keep the prescaler at 0x7F for A and power control

    rcc_guard #(
        .CNT_W (GUARD_W),
        .PRE_W (PRESC_W)
    ) u_guard (
        .clk     (clk),
        .reset   (reset),
        .start   (tx_end),
        .reload  (wait_val_r),
        .presc   (wait_pre_r),
        .busy    (guard_busy),
        .count_r (guard_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // receive datapath

    rcc_rx_state_type state_r;
    rcc_rx_state_type state_nxt;
    logic [2:0]       pos_r;
    logic [7:0]       shreg_r;
    logic [7:0]       shreg_set;
    logic             coll_seen_r;
    logic             take_start;
    logic             take_bit;
    logic             data_bit;
    logic             bit_val;
    logic             par_bit;
    logic             par_exp;
    logic             par_bad;
    logic             par_stop;
    logic             crc_init;
    logic [15:0]      crc_val;
    logic [15:0]      crc_residue;
    logic             crc_match;
    logic             frame_end;
    logic             byte_full;

    // the guard window swallows every start and bit the decoder delivers
    assign take_start = rx_start && !guard_busy && (state_r == RX_IDLE);
    assign take_bit   = rx_bit.valid && !guard_busy && (state_r != RX_IDLE);
    assign data_bit   = take_bit && (state_r == RX_DATA);
    assign par_bit    = take_bit && (state_r == RX_PARITY);
    // once a collision is seen, later bits are zeroed unless kept
    assign bit_val    = rx_bit.data && (cfg_r.keep_coll || !coll_seen_r);
    assign byte_full  = data_bit && (pos_r == ALIGN_LAST);

    generate
        for (genvar i = 0; i < 8; i++) begin : g_bit
            assign shreg_set[i] = shreg_r[i] | (data_bit && (pos_r == 3'(i)) && bit_val);
        end
    endgenerate

    assign par_exp   = (^shreg_r) ^ cfg_r.par_type;
    assign par_bad   = par_bit && (rx_bit.data != par_exp);
    assign par_stop  = par_bad && parity_stop_en;
    assign frame_end = (rx_end || par_stop) && (state_r != RX_IDLE);

    assign crc_init    = take_start;
    assign crc_residue = cfg_r.crc5 ? CRC5_RESIDUE :
                         (cfg_r.checksum_invert ? CRC16_RES_INV : CRC16_RESIDUE);
    assign crc_match   = (crc_val == crc_residue);

    rcc_crc u_crc (
        .clk    (clk),
        .reset  (reset),
        .init   (crc_init),
        .preset (rcc_preset(cfg_r.sel, cfg_r.preset, cfg_r.crc5)),
        .crc5   (cfg_r.crc5),
        .bit_en (data_bit),
        .bit_in (bit_val),
        .crc_r  (crc_val)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            RX_IDLE:   state_nxt = take_start ? RX_DATA : RX_IDLE;
            RX_DATA:   state_nxt = (byte_full && cfg_r.par_en) ? RX_PARITY : RX_DATA;
            RX_PARITY: state_nxt = par_bit ? RX_DATA : RX_PARITY;
        endcase
        if (frame_end) begin
            state_nxt = RX_IDLE;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r     <= RX_IDLE;
            pos_r       <= 3'h0;
            shreg_r     <= 8'h00;
            coll_seen_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (take_start) begin
                pos_r       <= cfg_r.align;
                shreg_r     <= 8'h00;
                coll_seen_r <= 1'b0;
            end else begin
                if (data_bit) begin
                    pos_r <= pos_r + 3'h1;
                end
                if (par_bit || (byte_full && !cfg_r.par_en)) begin
                    shreg_r <= 8'h00;
                end else begin
                    shreg_r <= shreg_set;
                end
                if (take_bit && rx_bit.coll) begin
                    coll_seen_r <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            byte_out_r <= '0;
        end else begin
            byte_out_r.valid <= (par_bit && !par_stop) || (byte_full && !cfg_r.par_en);
            byte_out_r.data  <= par_bit ? shreg_r : shreg_set;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            integrity_err_r <= 1'b0;
            crc_ok_r        <= 1'b0;
            frame_done_r    <= 1'b0;
            rx_open_r       <= 1'b0;
        end else begin
            rx_open_r    <= !guard_busy;
            frame_done_r <= frame_end;
            if (par_bad && !parity_stop_en) begin
                integrity_err_r <= 1'b1;
            end else if (frame_end && cfg_r.crc_en && !par_stop && !crc_match) begin
                integrity_err_r <= 1'b1;
            end else if (take_start) begin
                integrity_err_r <= 1'b0;
            end
            if (take_start) begin
                crc_ok_r <= 1'b0;
            end else if (frame_end) begin
                crc_ok_r <= cfg_r.crc_en && crc_match;
            end
        end
    end
endmodule : rcc_rx_check
`default_nettype wire

// ==== tb/rcc_card.sv ====
// card model: drives one decoded bit frame into the receive path
`timescale 1ns/1ps
`default_nettype none
module rcc_card (
    input  wire logic                clk,
    output logic                     rx_start,
    output logic                     rx_end,
    output var rcc_pkg::rcc_bit_type rx_bit
);
    import rcc_pkg::*;
    initial begin
        rx_start = 1'h0;
        rx_end = 1'h0;
        rx_bit = '0;
    end
    // gap cycles make a slow card; an idle data line shows the inverse, but the closing idle after a gap repeats the last bit
    task automatic send(input logic [127:0] b, input int n, input int cpos, input int gap);
        @(posedge clk);
        rx_start <= 1'h1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_start <= 1'h0;
            rx_bit <= '{1'h1, b[i], i == cpos};
            repeat (gap) @(posedge clk) rx_bit <= '{1'h0, ~b[i], 1'h0};
        end
        @(posedge clk);
        rx_start <= 1'h0;
        rx_bit <= '{1'h0, ~rx_bit.data, 1'h0};
        rx_end <= 1'h1;
        @(posedge clk);
        rx_end <= 1'h0;
    endtask : send
endmodule : rcc_card
`default_nettype wire

// ==== tb/rcc_rx_check_asserts.sv ====
// checker: port-level properties of the receive check block
`timescale 1ns/1ps
`default_nettype none
module rcc_rx_check_asserts #(
    parameter int GUARD_W = 20,
    parameter int PRESC_W = 8
) (
    input wire logic                       clk,
    input wire logic                       reset,
    input wire logic [rcc_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0]                wdata,
    input wire logic                       wr_en,
    input wire logic                       rd_en,
    input wire logic [31:0]                rdata_r,
    input wire logic                       tx_end,
    input wire logic                       rx_start,
    input wire logic                       auto_detect_en,
    input wire logic                       mode_valid,
    input wire rcc_pkg::rcc_mode_type      mode,
    input wire logic                       integrity_err_r,
    input wire logic                       crc_ok_r,
    input wire logic                       frame_done_r,
    input wire logic                       rx_open_r
);
    import rcc_pkg::*;
    logic [31:0] wd11_r;
    wire det_w = auto_detect_en && mode_valid;
    wire wr11_w = wr_en && addr == RCC_IDX_WAIT;
    wire wr12_w = wr_en && addr == RCC_IDX_CRC && !det_w;
    wire rd11_w = rd_en && addr == RCC_IDX_WAIT;
    wire rd12_w = rd_en && addr == RCC_IDX_CRC && !det_w;
    wire unmap_w = rd_en && addr != RCC_IDX_WAIT && addr != RCC_IDX_CRC && addr != RCC_IDX_STAT;
    logic [31:0] wd12_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd11_r <= 32'h0000_0000;
            wd12_r <= 32'h0000_0000;
        end else begin
            if (wr11_w) wd11_r <= wdata;
            if (wr_en && addr == RCC_IDX_CRC) wd12_r <= wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wr_rd11; wr11_w ##1 rd11_w; endsequence
    sequence s_wr_rd12; wr12_w ##1 rd12_w; endsequence
    sequence s_det(m); det_w && mode == m ##1 rd12_w; endsequence
    property p_rd_idle; !rd_en |=> rdata_r == 32'h0000_0000; endproperty
    property p_unmapped; unmap_w |=> rdata_r == 32'h0000_0000; endproperty
    property p_wait_rw; s_wr_rd11 |=> rdata_r == (wd11_r & 32'h0FFF_FFFF); endproperty
    property p_crc_rw; s_wr_rd12 |=> rdata_r == (wd12_r & 32'hFFFF_0FFF); endproperty
    property p_det_a;
        s_det(MODE_A) |=> rdata_r[11:10] == 2'h3 && rdata_r[5:3] == SEL_6363 && !rdata_r[1];
    endproperty
    property p_det_b; s_det(MODE_B) |=> rdata_r[5:3] == SEL_FFFF && rdata_r[1:0] == 2'h3; endproperty
    property p_guard_off; tx_end && wd11_r[27:8] == 20'h0_0000 |-> ##2 rx_open_r; endproperty
    // fixed reload 2, prescaler 1: closed for reload*(prescaler+1) cycles
    property p_guard_len;
        tx_end && wd11_r[27:0] == 28'h000_0201 |-> ##2 !rx_open_r [*4] ##1 rx_open_r;
    endproperty
    property p_err_hold; $fell(integrity_err_r) |-> $past(rx_start); endproperty
    property p_crc_rise; $rose(crc_ok_r) |-> frame_done_r; endproperty
    property p_done_pulse; frame_done_r |=> !frame_done_r; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_wait_rw: assert property (p_wait_rw) else $error("guard config readback");
    a_crc_rw: assert property (p_crc_rw) else $error("crc config readback");
    a_det_a: assert property (p_det_a) else $error("detector type A fields");
    a_det_b: assert property (p_det_b) else $error("detector type B fields");
    a_guard_off: assert property (p_guard_off) else $error("zero reload closed rx");
    a_guard_len: assert property (p_guard_len) else $error("guard length wrong");
    a_err_hold: assert property (p_err_hold) else $error("error flag dropped early");
    a_crc_rise: assert property (p_crc_rise) else $error("crc ok outside frame end");
    a_done_pulse: assert property (p_done_pulse) else $error("frame done too long");
endmodule : rcc_rx_check_asserts
bind rcc_rx_check rcc_rx_check_asserts #(.GUARD_W(GUARD_W), .PRESC_W(PRESC_W)) u_asserts (.*);
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench of the receive check block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rcc_pkg::*;
    logic clk, reset, wr_en, rd_en, tx_end, rx_start, rx_end;
    logic auto_detect_en, mode_valid, parity_stop_en;
    logic integrity_err_r, crc_ok_r, frame_done_r, rx_open_r;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata_r;
    rcc_bit_type rx_bit;
    rcc_mode_type mode;
    rcc_byte_type byte_out_r;
    int err_count, num_checks, seed;
    logic [7:0] got [$];
    rcc_rx_check uut (.*);
    rcc_card card (.*);
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) if (byte_out_r.valid === 1'h1) got.push_back(byte_out_r.data);
    initial begin
        #2_000_000;
        err_count++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic rst;
        reset <= 1'h1;
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
    endtask : rst
    // strobe stays up after a write so a read can follow with no gap
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge clk);
    endtask : wr
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        addr <= a;
        wr_en <= 1'h0;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        @(negedge clk);
        check(rdata_r, exp);
        @(posedge clk);
    endtask : rdc
    task automatic det(input int m);
        wr_en <= 1'h0;
        auto_detect_en <= (m < 4);
        mode <= rcc_mode_type'(m[1:0]);
        mode_valid <= 1'h1;
        @(posedge clk);
        mode_valid <= 1'h0;
    endtask : det
    task automatic tx;
        wr_en <= 1'h0;
        tx_end <= 1'h1;
        @(posedge clk);
        tx_end <= 1'h0;
    endtask : tx
    task automatic frame(input logic [127:0] b, input int n, input int cpos, input int gap);
        wr_en <= 1'h0;
        got.delete();
        card.send(b, n, cpos, gap);
        #1;
    endtask : frame
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] det_exp(input logic [31:0] w, input int m);
        logic [31:0] r;
        r = w & 32'hFFFF_0FFF;
        case (m)
            0: r[11:0] = {2'h3, r[9:6], SEL_6363, r[2], 1'h0, r[0]};
            1: r[5:0] = {SEL_FFFF, r[2], 2'h3};
            2: r[5:0] = {SEL_ZERO, r[2], 2'h1};
            default: r = r;
        endcase
        return r;
    endfunction : det_exp
    function automatic logic [15:0] preset_of(input int s, input logic [15:0] arb);
        case (s)
            1: return PRESET_6363;
            2: return PRESET_A671;
            3: return PRESET_FFFF;
            4: return PRESET_0012;
            5: return PRESET_E012;
            7: return arb;
            default: return PRESET_ZERO;
        endcase
    endfunction : preset_of
    function automatic logic [15:0] crc_of(input logic [15:0] d, input int n, input logic [15:0] p,
                                           input logic c5);
        logic [15:0] c;
        c = c5 ? p & 16'h001F : p;
        for (int i = 0; i < n; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? (c5 ? 16'h0012 : 16'h8408) : 16'h0000);
        return c;
    endfunction : crc_of
    // four bytes, each always followed by its parity bit; badp flips one
    function automatic logic [127:0] pack(input logic [31:0] d, input logic pt, input int badp);
        logic [127:0] b;
        b = '0;
        for (int i = 0; i < 4; i++) begin
            b[9*i +: 8] = d[8*i +: 8];
            b[9*i + 8] = ^d[8*i +: 8] ^ pt ^ (i == badp);
        end
        return b;
    endfunction : pack
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] w, v;
        logic [15:0] c;
        seed = 32'h3784_b0cb;
        err_count = 0;
        num_checks = 0;
        {reset, wr_en, rd_en, tx_end, auto_detect_en, mode_valid, parity_stop_en} = 7'h7F;
        {wr_en, rd_en, tx_end, auto_detect_en, mode_valid, parity_stop_en} = 6'h00;
        addr = 16'h0000;
        wdata = 32'h0000_0000;
        mode = MODE_A;
        rst();
        rdc(RCC_IDX_WAIT, 32'h0000_0000);
        rdc(RCC_IDX_CRC, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            w = $random(seed);
            wr(RCC_IDX_WAIT, w);
            rdc(RCC_IDX_WAIT, w & 32'h0FFF_FFFF);
            wr(RCC_IDX_CRC, w);
            rdc(RCC_IDX_CRC, w & 32'hFFFF_0FFF);
        end
        wr(16'h0013, ~w);
        rdc(16'h0013, 32'h0000_0000);
        rdc(RCC_IDX_CRC, w & 32'hFFFF_0FFF);
        for (int m = 0; m < 5; m++) begin
            w = $random(seed);
            wr(RCC_IDX_CRC, w);
            det(m);
            rdc(RCC_IDX_CRC, det_exp(w, m));
        end
        rst();
        rdc(RCC_IDX_CRC, 32'h0000_0000);
        wr(RCC_IDX_WAIT, 32'h0000_0201);
        rdc(RCC_IDX_WAIT, 32'h0000_0201);
        tx();
        frame(128'hA5, 8, 99, 0);
        check(got.size(), 0);
        wr(RCC_IDX_WAIT, 32'h0000_007F);
        rdc(RCC_IDX_WAIT, 32'h0000_007F);
        tx();
        frame(128'hA5, 8, 99, 0);
        check(got[0], 8'hA5);
        for (int s = 0; s < 8; s++) begin
            w = $random(seed);
            v = $random(seed);
            c = crc_of(v[15:0], 16, preset_of(s, w[31:16]), 1'h0);
            v[31:16] = s[0] ? ~c : c;
            parity_stop_en <= (s == 5);
            wr(RCC_IDX_CRC, {w[31:16], 4'h0, s[1], 1'h1, 4'h0, s[2:0], 1'h0, s[0], 1'h1});
            frame(pack(v, s[1], (s == 3 || s == 5) ? 0 : 9), 36, 99, s % 2);
            check(integrity_err_r, s == 3);
            if (s != 5) begin
                check({frame_done_r, crc_ok_r}, 2'h3);
                check({got[3], got[2], got[1], got[0]}, v);
            end
        end
        v = $random(seed);
        for (int e = 1; e >= 0; e--) begin
            c = crc_of(v[15:0], 8, v[31:16], 1'h1);
            wr(RCC_IDX_CRC, {v[31:16], 10'h000, 3'h7, 1'h1, 1'h0, 1'(e)});
            frame({c[4:0], v[7:0]}, 13, 99, 0);
            check({crc_ok_r, got[0]}, {1'(e), v[7:0]});
        end
        for (int a = 0; a < 4; a++) begin
            w = $random(seed);
            wr(RCC_IDX_CRC, {22'h00_0000, 1'(a), 3'(2 * a), 6'h00});
            v = a[0] ? w : w & ((32'h0000_0001 << (2 * a + 4)) - 1);
            v = v << (2 * a);
            frame(w, 16 - 2 * a, 2 * a + 3, 0);
            check({got[1], got[0]}, v[15:0]);
        end
        results();
    end
endmodule : tb_top
`default_nettype wire
